/* hw/bss_ahb.sv */
// Register slave on the bus: control, status and chain snapshot
module bss_ahb (
  input wire logic i_clk,          // System clock
  input wire logic i_rst_n,        // Synchronous reset, active low
  input wire logic i_hsel,         // Slave select
  input wire logic [31:0] i_haddr, // Address
  input wire logic [1:0] i_htrans, // Transfer type
  input wire logic i_hwrite,       // Write when high
  input wire logic [31:0] i_hwdata,// Write data
  input wire logic i_hready,       // Bus ready
  output logic [31:0] o_hrdata,    // Read data
  output logic o_hreadyout,        // Slave ready
  output logic o_hresp,            // Response, always OKAY
  bss_reg_if.slv regs              // Chain state and scan enable
);

  logic wr_q, wr_d, rd_q, rd_d, rd2_q, rd2_d, en_q, en_d;
  logic [7:0] addr_q, addr_d;
  logic [31:0] rdata_q, rdata_d;
  logic accept;

  function automatic logic [31:0] rd_mux(input logic [7:0] a, input logic en,
                                         input logic [126:0] ch, input logic [7:0] cnt,
                                         input logic [1:0] md);
    logic [127:0] wide;
    wide = {1'b0, ch};
    if (a == bss_pkg::REG_CTRL)
      return {31'h0000_0000, en};
    if (a == bss_pkg::REG_STAT)
      return {16'h0000, cnt, 6'h00, md};
    if (a >= bss_pkg::REG_CHAIN0 && a <= bss_pkg::REG_CHAIN3 && a[1:0] == 2'h0)
      return wide[32 * ((a - bss_pkg::REG_CHAIN0) >> 2) +: 32];
    return 32'h0000_0000;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  assign accept = i_hsel && i_htrans[1] && i_hready;

  always_comb
  begin
    wr_d = accept && i_hwrite;
    rd_d = accept && !i_hwrite;
    addr_d = accept ? i_haddr[7:0] : addr_q;
    rd2_d = 1'b0;
    rdata_d = rdata_q;
    en_d = en_q;
    // Reads take one wait state so read data come from a flip-flop
    if (rd_q && !rd2_q)
    begin
      rd_d = 1'b1;
      rd2_d = 1'b1;
      addr_d = addr_q;
      rdata_d = rd_mux(addr_q, en_q, regs.chain, regs.shift_cnt, regs.mode_q);
    end
    if (wr_q && addr_q == bss_pkg::REG_CTRL)
      en_d = i_hwdata[bss_pkg::CTRL_EN_BIT];
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      rd2_q <= 1'b0;
      addr_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
      en_q <= bss_pkg::CTRL_EN_RESET;
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      rd2_q <= rd2_d;
      addr_q <= addr_d;
      rdata_q <= rdata_d;
      en_q <= en_d;
    end
  end

  assign o_hreadyout = !(rd_q && !rd2_q);
  assign o_hrdata = rdata_q;
  assign o_hresp = 1'b0;
  assign regs.scan_en = en_q;

endmodule

/* hw/bss_chain.sv */
// Boundary scan chain register: serial shift and parallel capture
module bss_chain (
  input wire logic i_clk,   // System clock
  input wire logic i_rst_n, // Synchronous reset, active low
  bss_reg_if.chn bus        // Mode, capture data and chain state
);

  logic [126:0] chain_q;
  logic [126:0] chain_d;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    chain_d = chain_q;
    cnt_d = cnt_q;
    unique case (bus.mode_now)
      bss_pkg::BSS_SHIFT:
      begin
        chain_d = {chain_q[125:0], bus.ser_in};
        cnt_d = cnt_q + 8'h01;
      end
      bss_pkg::BSS_NORM:
      begin
        // Only input stages take pin levels; output stages keep the vector
        chain_d = (chain_q & ~bus.cap_mask) | (bus.pin_in & bus.cap_mask);
        cnt_d = 8'h00;
      end
      bss_pkg::BSS_FUNC:
      begin
        chain_d = chain_q;
      end
      default:
      begin
        chain_d = chain_q;
      end
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      chain_q <= bss_pkg::CHAIN_RESET;
      cnt_q <= 8'h00;
    end
    else
    begin
      chain_q <= chain_d;
      cnt_q <= cnt_d;
    end
  end

  assign bus.chain = chain_q;
  assign bus.shift_cnt = cnt_q;

  ////////////////////////////////////////////////////////////////////////
  AST_SHIFT_STEP: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    bus.mode_now == bss_pkg::BSS_SHIFT |=>
      chain_q == {$past(chain_q[125:0]), $past(bus.ser_in)})
    else $error("chain did not advance one stage in shift mode");

  AST_NORM_LOAD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    bus.mode_now == bss_pkg::BSS_NORM |=>
      ((chain_q ^ $past(bus.pin_in)) & $past(bus.cap_mask)) == '0)
    else $error("input stage missed the pin level in normal mode");

  AST_NORM_KEEP: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    bus.mode_now == bss_pkg::BSS_NORM |=>
      ((chain_q ^ $past(chain_q)) & ~$past(bus.cap_mask)) == '0)
    else $error("output stage changed during normal mode");

  AST_FUNC_FREEZE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    bus.mode_now == bss_pkg::BSS_FUNC [*2] |-> $stable(chain_q))
    else $error("chain moved outside scan mode");

endmodule

/* hw/bss_top.sv */
// Boundary scan of the bus interface pins, shift and normal sub-modes
//
// Notes on behaviour
// - In shift mode all pin stages form one register, one step per edge.
// - Serial input enters stage 0; stage 126 drives the bus request pin.
// - Previous response leaves on bus request while the new vector enters.
// - With reset and yield request asserted while shifting, three-state outputs float.
// - Entering normal puts the chain on pins; shift then unloads captures.
// - Normal mode drives outputs from latches and samples inputs together.
// - Each three-state group drives when its enable latch is one.
// - Data pins drive when data control is one, else are captured.
// - Normal mode loads every input latch with its pin level.
// - Enable high, select low is normal; both high is shift.
// - Chain holds input, output and group enable latches.
// - The last normal edge provides the captured response.
// - Scan mode starts at the edge enable is seen high, ends when low.
// - Sub-mode is sampled each edge from the shift select level.
module bss_top (
  input wire logic I_CLK,                      // 50 MHz clock
  input wire logic I_RESET_N,                  // Block reset, sync, low
  input wire logic I_HSEL,                     // Bus select
  input wire logic [31:0] I_HADDR,             // Bus address
  input wire logic [1:0] I_HTRANS,             // Bus transfer type
  input wire logic I_HWRITE,                   // Bus write
  input wire logic [2:0] I_HSIZE,              // Bus size, word only
  input wire logic [31:0] I_HWDATA,            // Bus write data
  input wire logic I_HREADY,                   // Bus ready
  output logic [31:0] O_HRDATA,                // Bus read data
  output logic O_HREADYOUT,                    // Slave ready
  output logic O_HRESP,                        // Slave response
  input wire logic I_BOUNDARY_TEST_ENABLE,     // Scan mode enable
  input wire logic I_CHAIN_SHIFT_SELECT,       // Shift when high
  input wire logic I_CHAIN_SERIAL_IN,          // Chain serial input
  input wire logic I_CPU_RESET,                // Processor reset pin
  input wire logic I_BUS_YIELD_REQUEST,        // Hold request pin
  input wire logic I_IRQ_OR_BOOTWIDTH_IN,      // Interrupt pin
  input wire logic I_NEXT_ADDRESS_IN_N,        // Next address pin
  input wire logic I_READY_N,                  // Transfer done pin
  input wire logic I_CACHEABLE_IN_N,           // Cacheable pin
  input wire logic [1:0] I_CACHE_CTL_IN,       // Cache control pins
  input wire logic [63:0] I_DATA_PINS,         // Data pin levels
  input wire logic [126:0] I_CORE_IMG,         // Core pin image, chain layout
  output logic [63:0] O_DATA_PINS,             // Data pin drive
  output logic O_DATA_OE_N,                    // Data enable, low drives
  output logic [28:0] O_ADDRESS_OUT_BITS,      // Address pins
  output logic O_ADDRESS_OE_N,                 // Address enable
  output logic [7:0] O_BYTE_LANE_ENABLES_N,    // Byte enable pins
  output logic O_BYTE_LANE_OE_N,               // Byte enable group enable
  output logic O_DIRECTION_OUT,                // Write/read pin
  output logic O_DIRECTION_OE_N,               // Write/read enable
  output logic O_NEXT_NEAR_OUT_N,              // Next near pin
  output logic O_NEXT_NEAR_OE_N,               // Next near enable
  output logic O_ADDRESS_STROBE_OUT_N,         // Address strobe pin
  output logic O_ADDRESS_STROBE_OE_N,          // Address strobe enable
  output logic O_ATOMIC_OUT_N,                 // Lock pin
  output logic O_ATOMIC_OE_N,                  // Lock enable
  output logic O_PAGE_TABLE_BIT_OUT_N,         // Page table bit pin
  output logic O_PAGE_TABLE_BIT_OE_N,          // Page table bit enable
  output logic O_YIELD_GRANT_OUT,              // Hold acknowledge pin
  output logic O_BUS_REQUEST_OUT               // Bus request, scan out
);

  bss_reg_if regs ();

  bss_pkg::bss_mode_t mode_now;
  bss_pkg::bss_mode_t mode_q;
  bss_pkg::bss_mode_t mode_d;
  logic [126:0] chain;
  logic [126:0] img;
  logic [126:0] pin_in;
  logic [126:0] cap_mask;
  logic [7:0] be_img;

  ////////////////////////////////////////////////////////////////////////
  // Group enable: float in shift so moving stages never reach the pins
  function automatic logic grp_oe_n(input bss_pkg::bss_mode_t m, input logic ctl);
    if (m == bss_pkg::BSS_SHIFT)
      return 1'b1;
    return !ctl;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  bss_ahb u_ahb (
    .i_clk(I_CLK),
    .i_rst_n(I_RESET_N),
    .i_hsel(I_HSEL),
    .i_haddr(I_HADDR),
    .i_htrans(I_HTRANS),
    .i_hwrite(I_HWRITE),
    .i_hwdata(I_HWDATA),
    .i_hready(I_HREADY),
    .o_hrdata(O_HRDATA),
    .o_hreadyout(O_HREADYOUT),
    .o_hresp(O_HRESP),
    .regs(regs)
  );

  bss_chain u_chain (
    .i_clk(I_CLK),
    .i_rst_n(I_RESET_N),
    .bus(regs)
  );

  ////////////////////////////////////////////////////////////////////////
  // Mode follows the pins at every edge, gated by the software enable
  assign mode_now = bss_pkg::mode_of(regs.scan_en, I_BOUNDARY_TEST_ENABLE,
                                     I_CHAIN_SHIFT_SELECT);

  always_comb
  begin
    mode_d = mode_now;
  end

  always_ff @(posedge I_CLK)
  begin
    if (!I_RESET_N)
      mode_q <= bss_pkg::BSS_FUNC;
    else
      mode_q <= mode_d;
  end

  assign chain = regs.chain;
  assign regs.mode_now = mode_now;
  assign regs.mode_q = mode_q;
  assign regs.ser_in = I_CHAIN_SERIAL_IN;
  assign regs.pin_in = pin_in;
  assign regs.cap_mask = cap_mask;

  ////////////////////////////////////////////////////////////////////////
  // Pin levels in chain layout; data stages listen only while undriven
  always_comb
  begin
    pin_in = '0;
    cap_mask = '0;
    pin_in[bss_pkg::P_SER_IN] = I_CHAIN_SERIAL_IN;
    pin_in[bss_pkg::P_TEST_EN] = I_BOUNDARY_TEST_ENABLE;
    pin_in[bss_pkg::P_SHIFT_SEL] = I_CHAIN_SHIFT_SELECT;
    pin_in[bss_pkg::P_CPU_RST] = I_CPU_RESET;
    pin_in[bss_pkg::P_DATA0 +: 64] = I_DATA_PINS;
    pin_in[bss_pkg::P_CACHE_CTL0 +: 2] = I_CACHE_CTL_IN;
    pin_in[bss_pkg::P_READY] = I_READY_N;
    pin_in[bss_pkg::P_CACHEABLE] = I_CACHEABLE_IN_N;
    pin_in[bss_pkg::P_NEXT_ADDR] = I_NEXT_ADDRESS_IN_N;
    pin_in[bss_pkg::P_IRQ] = I_IRQ_OR_BOOTWIDTH_IN;
    pin_in[bss_pkg::P_YIELD_REQ] = I_BUS_YIELD_REQUEST;
    cap_mask[bss_pkg::P_SER_IN +: 4] = 4'hF;
    cap_mask[bss_pkg::P_CACHE_CTL0 +: 2] = 2'h3;
    cap_mask[bss_pkg::P_READY +: 5] = 5'h1F;
    if (!chain[bss_pkg::P_DATA_CTL])
      cap_mask[bss_pkg::P_DATA0 +: 64] = '1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin image: test vector in normal mode, core image otherwise
  assign img = (mode_q == bss_pkg::BSS_NORM) ? chain : I_CORE_IMG;

  // Byte enables sit reversed: lane 0 is next to the request stage
  always_comb
  begin
    be_img = '0;
    for (int i = 0; i < 8; i++)
      be_img[i] = img[bss_pkg::P_BYTE7 + 7 - i];
  end

  assign O_DATA_PINS = img[bss_pkg::P_DATA0 +: 64];
  assign O_DATA_OE_N = grp_oe_n(mode_q, img[bss_pkg::P_DATA_CTL]);
  assign O_ADDRESS_OUT_BITS = img[bss_pkg::P_ADDR0 +: 29];
  assign O_ADDRESS_OE_N = grp_oe_n(mode_q, img[bss_pkg::P_ADDR_CTL]);
  assign O_BYTE_LANE_ENABLES_N = be_img;
  assign O_BYTE_LANE_OE_N = grp_oe_n(mode_q, img[bss_pkg::P_BYTE_CTL]);
  assign O_DIRECTION_OUT = img[bss_pkg::P_DIR];
  assign O_DIRECTION_OE_N = grp_oe_n(mode_q, img[bss_pkg::P_DIR_CTL]);
  assign O_NEXT_NEAR_OUT_N = img[bss_pkg::P_NN];
  assign O_NEXT_NEAR_OE_N = grp_oe_n(mode_q, img[bss_pkg::P_NN_CTL]);
  assign O_ADDRESS_STROBE_OUT_N = img[bss_pkg::P_STRB];
  assign O_ADDRESS_STROBE_OE_N = grp_oe_n(mode_q, img[bss_pkg::P_STRB_CTL]);
  assign O_ATOMIC_OUT_N = img[bss_pkg::P_ATOM];
  assign O_ATOMIC_OE_N = grp_oe_n(mode_q, img[bss_pkg::P_ATOM_CTL]);
  assign O_PAGE_TABLE_BIT_OUT_N = img[bss_pkg::P_PAGE];
  assign O_PAGE_TABLE_BIT_OE_N = grp_oe_n(mode_q, img[bss_pkg::P_PAGE_CTL]);
  assign O_YIELD_GRANT_OUT = img[bss_pkg::P_YIELD_GNT];
  // Scan out is the top stage, so the old response leaves first
  assign O_BUS_REQUEST_OUT = (mode_q == bss_pkg::BSS_SHIFT) ?
                             chain[bss_pkg::P_BUS_REQ] :
                             img[bss_pkg::P_BUS_REQ];

  ////////////////////////////////////////////////////////////////////////
  AST_SER_OUT: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    mode_q == bss_pkg::BSS_SHIFT && mode_now == bss_pkg::BSS_SHIFT |=>
      O_BUS_REQUEST_OUT == $past(chain[125]))
    else $error("scan out did not present the next stage");

  AST_FLOAT: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    mode_q == bss_pkg::BSS_SHIFT && I_CPU_RESET && I_BUS_YIELD_REQUEST |->
      O_DATA_OE_N && O_ADDRESS_OE_N && O_BYTE_LANE_OE_N && O_DIRECTION_OE_N &&
      O_NEXT_NEAR_OE_N && O_ADDRESS_STROBE_OE_N && O_ATOMIC_OE_N &&
      O_PAGE_TABLE_BIT_OE_N)
    else $error("three-state output driven while shifting");

  AST_ADDR_DRV: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    mode_q == bss_pkg::BSS_NORM |->
      O_ADDRESS_OE_N == !chain[bss_pkg::P_ADDR_CTL] &&
      O_BYTE_LANE_OE_N == !chain[bss_pkg::P_BYTE_CTL] &&
      O_BYTE_LANE_ENABLES_N[0] == chain[125])
    else $error("group drive does not follow its enable latch");

  AST_DATA_DRV: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    mode_q == bss_pkg::BSS_NORM && !chain[bss_pkg::P_DATA_CTL] &&
      mode_now == bss_pkg::BSS_NORM |=>
      O_DATA_OE_N && chain[bss_pkg::P_DATA0 +: 64] == $past(I_DATA_PINS))
    else $error("undriven data pins were not captured");

  AST_ENTRY: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    regs.scan_en && I_BOUNDARY_TEST_ENABLE |=> mode_q != bss_pkg::BSS_FUNC)
    else $error("scan mode not entered at the first enabled edge");

  AST_EXIT: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    mode_q != bss_pkg::BSS_FUNC ##1 !I_BOUNDARY_TEST_ENABLE |=>
      mode_q == bss_pkg::BSS_FUNC)
    else $error("scan mode not left after enable fell");

  AST_LAST_CAPTURE: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    mode_now == bss_pkg::BSS_NORM ##1 mode_now == bss_pkg::BSS_SHIFT |=>
      chain[bss_pkg::P_IRQ + 1] == $past(I_IRQ_OR_BOOTWIDTH_IN, 2))
    else $error("response is not the last normal edge capture");

  AST_NORM_PINS: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    mode_q == bss_pkg::BSS_NORM |->
      O_ADDRESS_OUT_BITS == chain[bss_pkg::P_ADDR0 +: 29] &&
      O_DIRECTION_OUT == chain[bss_pkg::P_DIR])
    else $error("normal mode pins differ from the chain");

  AST_FUNC_PINS: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    mode_q == bss_pkg::BSS_FUNC |->
      O_ADDRESS_OUT_BITS == I_CORE_IMG[bss_pkg::P_ADDR0 +: 29] &&
      O_BUS_REQUEST_OUT == I_CORE_IMG[bss_pkg::P_BUS_REQ])
    else $error("pins left the core outside scan mode");

endmodule

/* include/bss_if.sv */
// Signals between the scan top, the chain register and the bus slave
interface bss_reg_if;
  bss_pkg::bss_mode_t mode_now;
  bss_pkg::bss_mode_t mode_q;
  logic ser_in;
  logic [126:0] cap_mask;
  logic [126:0] pin_in;
  logic [126:0] chain;
  logic [7:0] shift_cnt;
  logic scan_en;

  modport chn(input mode_now, ser_in, cap_mask, pin_in, output chain, shift_cnt);
  modport slv(input chain, shift_cnt, mode_q, output scan_en);
endinterface

/* include/bss_pkg.sv */
// Constants and types shared by the boundary scan block
package bss_pkg;

  // Chain length and stage positions, stage 0 next to the serial input
  localparam int CHAIN_LEN = 127;
  localparam int P_SER_IN = 0;
  localparam int P_TEST_EN = 1;
  localparam int P_SHIFT_SEL = 2;
  localparam int P_CPU_RST = 3;
  localparam int P_DATA_CTL = 4;
  localparam int P_DATA0 = 5;
  localparam int P_CACHE_CTL0 = 69;
  localparam int P_ADDR_CTL = 71;
  localparam int P_ADDR0 = 72;
  localparam int P_NN_CTL = 101;
  localparam int P_NN = 102;
  localparam int P_PAGE_CTL = 103;
  localparam int P_PAGE = 104;
  localparam int P_DIR_CTL = 105;
  localparam int P_DIR = 106;
  localparam int P_STRB_CTL = 107;
  localparam int P_STRB = 108;
  localparam int P_ATOM_CTL = 109;
  localparam int P_ATOM = 110;
  localparam int P_READY = 111;
  localparam int P_CACHEABLE = 112;
  localparam int P_NEXT_ADDR = 113;
  localparam int P_IRQ = 114;
  localparam int P_YIELD_REQ = 115;
  localparam int P_YIELD_GNT = 116;
  localparam int P_BYTE_CTL = 117;
  localparam int P_BYTE7 = 118;
  localparam int P_BUS_REQ = 126;

  // Register map, byte addresses on the bus
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_CHAIN0 = 8'h08;
  localparam logic [7:0] REG_CHAIN3 = 8'h14;
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RESET = 1'b1;
  localparam logic [126:0] CHAIN_RESET = '0;

  typedef enum logic [1:0] {
    BSS_FUNC = 2'b00,
    BSS_NORM = 2'b01,
    BSS_SHIFT = 2'b10
  } bss_mode_t;

  // Test mode from enable pins and software enable; low enable is functional whatever the select
  function automatic bss_mode_t mode_of(input logic en, input logic test_en,
                                        input logic shift_sel);
    if (!en || !test_en)
      return BSS_FUNC;
    return shift_sel ? BSS_SHIFT : BSS_NORM;
  endfunction

endpackage

/* testbench/bss_tester.sv */
// Board tester model that drives the scan control pins and walks the chain
module bss_tester (
  input wire logic i_clk,  // System clock
  input wire logic i_bout, // Serial output seen on the bus request pin
  output logic o_en,       // Scan enable
  output logic o_sel,      // Shift select
  output logic o_si,       // Serial data into the chain
  output logic o_cpu_rst,  // Processor reset pin
  output logic o_hold      // Yield request pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    o_en = 1'b0;
    o_sel = 1'b0;
    o_si = 1'b0;
    o_cpu_rst = 1'b1;
    o_hold = 1'b0;
  end
  ////////////////////////////////////////
  // Reset stays high: core state is undefined after scan
  task automatic mode(input logic en, input logic sel);
    @(posedge i_clk);
    o_en <= en;
    o_sel <= sel;
    o_hold <= en;
    o_cpu_rst <= 1'b1;
  endtask
  // First bit goes out with the select, so exactly 127 edges shift
  task automatic shift_vec(input logic [126:0] v, output logic [126:0] got);
    mode(1'b1, 1'b1);
    o_si <= v[126];
    for (int i = 126; i >= 0; i--)
    begin
      @(negedge i_clk);
      got[i] = i_bout;
      if (i > 0)
      begin
        @(posedge i_clk);
        o_si <= v[i - 1];
      end
    end
    mode(1'b1, 1'b0);
  endtask
endmodule

/* testbench/bss_top_test.sv */
// Self-checking bench for the boundary scan block
module bss_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, hsel, hwrite, irq, na_n, rdy_n, ken_n, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, cc;
  logic [63:0] ext_d, d_out;
  logic [126:0] core;
  logic [28:0] addr;
  logic [7:0] be;
  logic en, sel, si, cpu_rst, hold, hrdy, bus_request_out, gnt, dir, nn, strb, atom, pg;
  logic d_oe_n, addr_oe_n, be_oe_n, dir_oe_n, nn_oe_n, strb_oe_n, atom_oe_n, pg_oe_n;
  wire logic [63:0] dlvl = d_oe_n ? ext_d : d_out;
  wire logic [7:0] oe_all = {d_oe_n, addr_oe_n, be_oe_n, dir_oe_n, nn_oe_n, strb_oe_n,
                             atom_oe_n, pg_oe_n};
  int num_errors;
  int checked;
  bss_top bss_top_i (.I_CLK(clk), .I_RESET_N(rst_n), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata),
    .I_HREADY(hrdy), .O_HRDATA(hrdata), .O_HREADYOUT(hrdy), .O_HRESP(hresp),
    .I_BOUNDARY_TEST_ENABLE(en), .I_CHAIN_SHIFT_SELECT(sel), .I_CHAIN_SERIAL_IN(si),
    .I_CPU_RESET(cpu_rst), .I_BUS_YIELD_REQUEST(hold), .I_IRQ_OR_BOOTWIDTH_IN(irq),
    .I_NEXT_ADDRESS_IN_N(na_n), .I_READY_N(rdy_n), .I_CACHEABLE_IN_N(ken_n),
    .I_CACHE_CTL_IN(cc), .I_DATA_PINS(dlvl), .I_CORE_IMG(core), .O_DATA_PINS(d_out),
    .O_DATA_OE_N(d_oe_n), .O_ADDRESS_OUT_BITS(addr), .O_ADDRESS_OE_N(addr_oe_n),
    .O_BYTE_LANE_ENABLES_N(be), .O_BYTE_LANE_OE_N(be_oe_n), .O_DIRECTION_OUT(dir),
    .O_DIRECTION_OE_N(dir_oe_n), .O_NEXT_NEAR_OUT_N(nn), .O_NEXT_NEAR_OE_N(nn_oe_n),
    .O_ADDRESS_STROBE_OUT_N(strb), .O_ADDRESS_STROBE_OE_N(strb_oe_n),
    .O_ATOMIC_OUT_N(atom), .O_ATOMIC_OE_N(atom_oe_n), .O_PAGE_TABLE_BIT_OUT_N(pg),
    .O_PAGE_TABLE_BIT_OE_N(pg_oe_n), .O_YIELD_GRANT_OUT(gnt), .O_BUS_REQUEST_OUT(bus_request_out));
  bss_tester tester_i (.i_clk(clk), .i_bout(bus_request_out), .o_en(en), .o_sel(sel), .o_si(si),
    .o_cpu_rst(cpu_rst), .o_hold(hold));
  ////////////////////////////////////////
  function automatic logic [7:0] oe_exp(input logic [126:0] v);
    return ~{v[4], v[71], v[117], v[105], v[101], v[107], v[109], v[103]};
  endfunction
  // Data ctl low, group ctls high, or the reverse
  function automatic logic [126:0] mk(input logic [126:0] b, input logic c);
    logic [126:0] e;
    e = b;
    e[4] = c;
    foreach (e[i])
      if (i inside {71, 101, 103, 105, 107, 109, 117})
        e[i] = !c;
    return e;
  endfunction
  // Chain image after a normal interval with the present pin levels
  function automatic logic [126:0] cap(input logic [126:0] v);
    logic [126:0] e;
    e = v;
    e[3:1] = 3'h5;
    if (!v[4])
      e[68:5] = ext_d;
    e[70:69] = cc;
    e[115:111] = {1'b1, irq, na_n, ken_n, rdy_n};
    return e;
  endfunction
  task automatic chk(input logic [126:0] got, input logic [126:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    chk(127'({hresp, r}), 127'({1'b0, exp}));
  endtask
  task automatic chain(input logic [126:0] e);
    for (int k = 0; k < 4; k++)
      rchk(bss_pkg::REG_CHAIN0 + 8'(4 * k), 32'({1'b0, e} >> (32 * k)));
  endtask
  task automatic pins(input logic [126:0] v);
    logic [7:0] rb;
    for (int i = 0; i < 8; i++)
      rb[i] = v[125 - i];
    chk(127'({nn, pg, be}), 127'({v[102], v[104], rb}));
    chk(127'(oe_all), 127'(oe_exp(v)));
    chk(127'({addr, dir, strb, gnt, atom}), 127'({v[100:72], v[106], v[108], v[116], v[110]}));
    if (v[4])
      chk(127'(d_out), 127'(v[68:5]));
  endtask
  task automatic fchk();
    @(posedge clk);
    @(negedge clk);
    chk(127'({bus_request_out, oe_all}), 127'({core[126], oe_exp(core)}));
  endtask
  task automatic wrap_up();
    $display("Comparisons %0d, errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Full run is under 1500 cycles
  initial
  begin
    #100000;
    num_errors++;
    wrap_up();
  end
  initial
  begin
    logic [126:0] v1, v2, got;
    logic [31:0] r;
    {rst_n, hsel, hwrite, irq, rdy_n, haddr, htrans, hwdata} = '0;
    {na_n, ken_n, cc, ext_d} = {2'h3, 2'h1, 64'h0123_4567_89AB_CDEF};
    core = 127'({4{32'h96E1_A53C}});
    num_errors = 0;
    checked = 0;
    v1 = mk(127'({4{32'hA53C_96E1}}), 1'b0);
    v2 = mk(127'({4{32'h3CA5_1E96}}), 1'b1);
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rchk(bss_pkg::REG_CTRL, 32'h1);
    rchk(bss_pkg::REG_STAT, 32'h0);
    ahb(1'b1, 8'h40, 32'hFFFF_FFFF, r);
    rchk(8'h40, 32'h0);
    tester_i.mode(1'b0, 1'b1);
    fchk();
    ahb(1'b1, bss_pkg::REG_CTRL, 32'h0, r);
    tester_i.mode(1'b1, 1'b1);
    fchk();
    rchk(bss_pkg::REG_CHAIN0, 32'h0);
    tester_i.mode(1'b0, 1'b0);
    ahb(1'b1, bss_pkg::REG_CTRL, 32'h1, r);
    tester_i.shift_vec(v1, got);
    chk(got, 127'h0);
    #1;
    chk(127'(oe_all), 127'(8'hFF));
    @(posedge clk);
    @(negedge clk);
    pins(v1);
    chain(cap(v1));
    ahb(1'b0, bss_pkg::REG_STAT, 32'h0, r);
    chk(127'(r[1:0]), 127'(2'h1));
    @(posedge clk);
    irq <= 1'b1;
    rdy_n <= 1'b1;
    cc <= 2'h2;
    ext_d <= ~ext_d;
    tester_i.shift_vec(v2, got);
    chk(got, cap(v1));
    @(posedge clk);
    @(negedge clk);
    pins(v2);
    tester_i.shift_vec(v1, got);
    chk(got, cap(v2));
    // Back to back: a single normal edge between the two vectors
    tester_i.shift_vec(v2, got);
    chk(got, cap(v1));
    tester_i.mode(1'b0, 1'b0);
    fchk();
    wrap_up();
  end
endmodule
